// ---- src/rte_consts.svh ----
// Constants for the peripheral pin routing block
`ifndef RTE_CONSTS_SVH
`define RTE_CONSTS_SVH

`define RTE_NUM_PINS      24
`define RTE_NUM_INPUTS    8
`define RTE_NUM_CODES     64
`define RTE_IN_SEL_W      5
`define RTE_OUT_SEL_W     6
`define RTE_IDX_W         5

// Lock register key bytes and lock bit position
`define RTE_KEY_FIRST     8'h55
`define RTE_KEY_SECOND    8'haa
`define RTE_LOCK_BIT      0

// Output select reset code: ordinary port latch
`define RTE_OUT_SEL_RST   6'h00

// Output source codes
`define RTE_CODE_LATCH    6'h00
`define RTE_CODE_LOGIC1   6'h01
`define RTE_CODE_WAVE1A   6'h05
`define RTE_CODE_CAPCMP1  6'h09
`define RTE_CODE_PWM_A    6'h0d
`define RTE_CODE_PWM_B    6'h0e
`define RTE_CODE_SER_CK   6'h0f
`define RTE_CODE_SER_DT   6'h10
`define RTE_CODE_CMP1     6'h11
`define RTE_CODE_CMP2     6'h12
`define RTE_CODE_P1_CLK   6'h13
`define RTE_CODE_P1_DAT   6'h14
`define RTE_CODE_P2_CLK   6'h15
`define RTE_CODE_P2_DAT   6'h16
`define RTE_CODE_TMR0     6'h17
`define RTE_CODE_NUMOSC   6'h18
`define RTE_CODE_REFCLK   6'h19
`define RTE_CODE_MOD      6'h1a
`define RTE_CODE_WAVE2A   6'h1b
`define RTE_CODE_GUARD_A  6'h1f
`define RTE_CODE_GUARD_B  6'h20

// Input select indices
`define RTE_IN_SS1        0
`define RTE_IN_SCL2       1
`define RTE_IN_SDA2       2
`define RTE_IN_SS2        3
`define RTE_IN_RX1        4
`define RTE_IN_CK1        5
`define RTE_IN_SMTSIG     6
`define RTE_IN_SMTWIN     7

// Input select defaults, small package
`define RTE_DEF14_SS1     5'h13
`define RTE_DEF14_SCL2    5'h14
`define RTE_DEF14_SDA2    5'h15
`define RTE_DEF14_SS2     5'h00
`define RTE_DEF14_RX1     5'h15
`define RTE_DEF14_CK1     5'h14
`define RTE_DEF14_SMTSIG  5'h10
`define RTE_DEF14_SMTWIN  5'h04

// Input select defaults, 20-pin package
`define RTE_DEF20_SS1     5'h16
`define RTE_DEF20_SCL2    5'h0f
`define RTE_DEF20_SDA2    5'h0d
`define RTE_DEF20_SS2     5'h01
`define RTE_DEF20_RX1     5'h0d
`define RTE_DEF20_CK1     5'h0f
`define RTE_DEF20_SMTSIG  5'h10
`define RTE_DEF20_SMTWIN  5'h04

`endif

// ---- src/rte_pkg.sv ----
// Types for the peripheral pin routing block
`default_nettype none

package rte_pkg;

    typedef enum logic [1:0] {
        RTE_KEY_IDLE,
        RTE_KEY_GOT_FIRST,
        RTE_KEY_GOT_SECOND
    } rte_key_e;

endpackage

`default_nettype wire

// ---- src/rte_pin_drive.sv ----
// Per-pin output source and driver enable selection
`include "rte_consts.svh"
`default_nettype none

module rte_pin_drive (
    input  wire logic [`RTE_OUT_SEL_W-1:0] outSel,    // Output select code
    input  wire logic [`RTE_NUM_CODES-1:0] srcVal,    // Source level per code
    input  wire logic [`RTE_NUM_CODES-1:0] ovrAct,    // Peripheral owns driver
    input  wire logic [`RTE_NUM_CODES-1:0] ovrOe,     // Peripheral driver enable
    input  wire logic                      dirInput,  // Direction bit, 1 = input
    output logic                           drvVal,    // Pin output level
    output logic                           drvOe      // Pin output enable
);

    always_comb begin
        drvVal = srcVal[outSel];
        if (ovrAct[outSel]) begin
            drvOe = ovrOe[outSel];
        end else begin
            drvOe = ~dirInput;
        end
    end

endmodule

`default_nettype wire

// ---- src/rte_pin_routing.sv ----
// Peripheral pin routing fabric with selection lock
`include "rte_consts.svh"
`default_nettype none

module rte_pin_routing #(
    parameter bit PKG20 = 1'b1                        // 1 = 20-pin package defaults
) (
    input  wire logic                      mclk,          // System clock
    input  wire logic                      rst_n,         // Power-on reset, active low
    input  wire logic                      selWrEn,       // Select register write strobe
    input  wire logic                      selWrOut,      // 1 = output select, 0 = input
    input  wire logic [`RTE_IDX_W-1:0]     selWrIdx,      // Pin or input index
    input  wire logic [7:0]                selWrData,     // Write data
    input  wire logic                      lockWrEn,      // Lock register write strobe
    input  wire logic [7:0]                lockWrData,    // Lock register write data
    input  wire logic                      otherAccess,   // Any other register access
    input  wire logic                      oneWayCfg,     // One-way lock option
    input  wire logic [`RTE_NUM_PINS-1:0]  pinIn,         // Pin levels, asynchronous
    input  wire logic [`RTE_NUM_PINS-1:0]  portLatch,     // Port output latch values
    input  wire logic [`RTE_NUM_PINS-1:0]  pinDirCtrl,    // Direction bits, 1 = input
    input  wire logic [3:0]                logicCellOut,  // Logic cell outputs 1-4
    input  wire logic [3:0]                wave1Out,      // Generator 1 outputs A-D
    input  wire logic [3:0]                wave2Out,      // Generator 2 outputs A-D
    input  wire logic [3:0]                capCompOut,    // Capture/compare outputs 1-4
    input  wire logic [1:0]                pwmOut,        // PWM outputs A and B
    input  wire logic [1:0]                cmpOut,        // Comparator outputs 1 and 2
    input  wire logic                      serTxCk,       // Serial TX or sync clock out
    input  wire logic                      serDt,         // Serial sync data out
    input  wire logic                      serSyncMode,   // Serial port in sync mode
    input  wire logic                      serCkOe,       // Serial clock driver enable
    input  wire logic                      serDtOe,       // Serial data driver enable
    input  wire logic [1:0]                sspClk,        // Sync ports clock out
    input  wire logic [1:0]                sspDat,        // Sync ports data out
    input  wire logic [1:0]                sspI2cMode,    // Sync ports in I2C mode
    input  wire logic [1:0]                sspClkOe,      // Sync ports clock enable
    input  wire logic [1:0]                sspDatOe,      // Sync ports data enable
    input  wire logic                      timer_zero_output,       // Timer zero output
    input  wire logic                      numOscOut,     // Numeric oscillator output
    input  wire logic                      refClkOut,     // Reference clock output
    input  wire logic                      modOut,        // Modulator output
    input  wire logic [1:0]                guardOut,      // Converter guards A and B
    output logic [`RTE_NUM_INPUTS-1:0]     periphIn,      // Routed peripheral inputs
    output logic [`RTE_NUM_PINS-1:0]       pinOut,        // Pin output levels
    output logic [`RTE_NUM_PINS-1:0]       pinOe,         // Pin output enables
    output logic                           lockedOut      // Routing locked bit
);

    // ****************************************************************
    // Reset defaults
    // ****************************************************************
    localparam logic [`RTE_NUM_INPUTS*`RTE_IN_SEL_W-1:0] DEF14 = {
        `RTE_DEF14_SMTWIN, `RTE_DEF14_SMTSIG, `RTE_DEF14_CK1, `RTE_DEF14_RX1,
        `RTE_DEF14_SS2, `RTE_DEF14_SDA2, `RTE_DEF14_SCL2, `RTE_DEF14_SS1};
    localparam logic [`RTE_NUM_INPUTS*`RTE_IN_SEL_W-1:0] DEF20 = {
        `RTE_DEF20_SMTWIN, `RTE_DEF20_SMTSIG, `RTE_DEF20_CK1, `RTE_DEF20_RX1,
        `RTE_DEF20_SS2, `RTE_DEF20_SDA2, `RTE_DEF20_SCL2, `RTE_DEF20_SS1};
    localparam logic [`RTE_NUM_INPUTS*`RTE_IN_SEL_W-1:0] IN_DEF = PKG20 ? DEF20 : DEF14;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`RTE_NUM_PINS-1:0] pinMeta_r;
    logic [`RTE_NUM_PINS-1:0] pinSync_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end else begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
        end
    end

    // ****************************************************************
    // Lock key sequence
    // ****************************************************************
    rte_pkg::rte_key_e keySt_r;
    rte_pkg::rte_key_e keySt_nxt;
    logic              locked_r;
    logic              locked_nxt;
    logic              oneWaySet_r;
    logic              oneWaySet_nxt;

    always_comb begin
        keySt_nxt     = keySt_r;
        locked_nxt    = locked_r;
        oneWaySet_nxt = oneWaySet_r;
        if (selWrEn || otherAccess) begin
            keySt_nxt = rte_pkg::RTE_KEY_IDLE;
        end else if (lockWrEn) begin
            case (keySt_r)
                rte_pkg::RTE_KEY_IDLE: begin
                    if (lockWrData == `RTE_KEY_FIRST) begin
                        keySt_nxt = rte_pkg::RTE_KEY_GOT_FIRST;
                    end
                end
                rte_pkg::RTE_KEY_GOT_FIRST: begin
                    if (lockWrData == `RTE_KEY_SECOND) begin
                        keySt_nxt = rte_pkg::RTE_KEY_GOT_SECOND;
                    end else begin
                        keySt_nxt = rte_pkg::RTE_KEY_IDLE;
                    end
                end
                rte_pkg::RTE_KEY_GOT_SECOND: begin
                    keySt_nxt = rte_pkg::RTE_KEY_IDLE;
                    if (lockWrData[`RTE_LOCK_BIT]) begin
                        locked_nxt = 1'b1;
                        if (oneWayCfg) begin
                            oneWaySet_nxt = 1'b1;
                        end
                    end else if (!oneWaySet_r) begin
                        locked_nxt = 1'b0;
                    end
                end
                default: begin
                    keySt_nxt = rte_pkg::RTE_KEY_IDLE;
                end
            endcase
        end
    end

    // Only power-on reset reaches here; sleep has no effect
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            keySt_r     <= rte_pkg::RTE_KEY_IDLE;
            locked_r    <= 1'b0;
            oneWaySet_r <= 1'b0;
        end else begin
            keySt_r     <= keySt_nxt;
            locked_r    <= locked_nxt;
            oneWaySet_r <= oneWaySet_nxt;
        end
    end

    // ****************************************************************
    // Selection registers
    // ****************************************************************
    logic [`RTE_IN_SEL_W-1:0]  inSel_r  [`RTE_NUM_INPUTS];
    logic [`RTE_IN_SEL_W-1:0]  inSel_nxt [`RTE_NUM_INPUTS];
    logic [`RTE_OUT_SEL_W-1:0] outSel_r  [`RTE_NUM_PINS];
    logic [`RTE_OUT_SEL_W-1:0] outSel_nxt [`RTE_NUM_PINS];

    always_comb begin
        for (int i = 0; i < `RTE_NUM_INPUTS; i++) begin
            inSel_nxt[i] = inSel_r[i];
        end
        for (int p = 0; p < `RTE_NUM_PINS; p++) begin
            outSel_nxt[p] = outSel_r[p];
        end
        if (selWrEn && !locked_r) begin
            if (selWrOut) begin
                if (32'(selWrIdx) < `RTE_NUM_PINS) begin
                    outSel_nxt[selWrIdx] = selWrData[`RTE_OUT_SEL_W-1:0];
                end
            end else if (32'(selWrIdx) < `RTE_NUM_INPUTS) begin
                inSel_nxt[selWrIdx[2:0]] = selWrData[`RTE_IN_SEL_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Per-input and per-pin logic
    // ****************************************************************
    logic [`RTE_NUM_CODES-1:0] srcVal;
    logic [`RTE_NUM_CODES-1:0] ovrAct;
    logic [`RTE_NUM_CODES-1:0] ovrOe;
    logic [`RTE_NUM_PINS-1:0]  drvVal;
    logic [`RTE_NUM_PINS-1:0]  drvOe;

    always_comb begin
        ovrAct = '0;
        ovrOe  = '0;
        ovrAct[`RTE_CODE_SER_CK]  = serSyncMode;
        ovrAct[`RTE_CODE_SER_DT]  = serSyncMode;
        ovrOe[`RTE_CODE_SER_CK]   = serCkOe;
        ovrOe[`RTE_CODE_SER_DT]   = serDtOe;
        ovrAct[`RTE_CODE_P1_CLK]  = sspI2cMode[0];
        ovrAct[`RTE_CODE_P1_DAT]  = sspI2cMode[0];
        ovrAct[`RTE_CODE_P2_CLK]  = sspI2cMode[1];
        ovrAct[`RTE_CODE_P2_DAT]  = sspI2cMode[1];
        ovrOe[`RTE_CODE_P1_CLK]   = sspClkOe[0];
        ovrOe[`RTE_CODE_P1_DAT]   = sspDatOe[0];
        ovrOe[`RTE_CODE_P2_CLK]   = sspClkOe[1];
        ovrOe[`RTE_CODE_P2_DAT]   = sspDatOe[1];
    end

    // Code 0 is patched per pin with its own latch
    assign srcVal[`RTE_NUM_CODES-1:`RTE_CODE_GUARD_B+1] = '0;
    assign srcVal[`RTE_CODE_GUARD_B:`RTE_CODE_LOGIC1] = {
        guardOut, wave2Out[3:0], modOut, refClkOut, numOscOut, timer_zero_output,
        sspDat[1], sspClk[1], sspDat[0], sspClk[0], cmpOut, serDt, serTxCk,
        pwmOut, capCompOut, wave1Out, logicCellOut};
    assign srcVal[`RTE_CODE_LATCH] = 1'b0;

    logic [`RTE_NUM_INPUTS-1:0] periphIn_nxt;
    // Codes beyond the last pin read low
    logic [31:0]                pinPad;

    assign pinPad = {8'h00, pinSync_r};

    genvar g;
    generate
        for (g = 0; g < `RTE_NUM_INPUTS; g++) begin : g_in
            // Port in upper bits, pin in lower bits; RX and CK selects serve sync mode
            assign periphIn_nxt[g] =
                pinPad[{inSel_r[g][4:3], inSel_r[g][2:0]}];
        end
        for (g = 0; g < `RTE_NUM_PINS; g++) begin : g_pin
            logic [`RTE_NUM_CODES-1:0] pinSrc;
            assign pinSrc = {srcVal[`RTE_NUM_CODES-1:1], portLatch[g]};
            rte_pin_drive u_drive (
                .outSel   (outSel_r[g]),
                .srcVal   (pinSrc),
                .ovrAct   (ovrAct),
                .ovrOe    (ovrOe),
                .dirInput (pinDirCtrl[g]),
                .drvVal   (drvVal[g]),
                .drvOe    (drvOe[g])
            );
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RTE_NUM_INPUTS; i++) begin
                inSel_r[i] <= IN_DEF[i*`RTE_IN_SEL_W +: `RTE_IN_SEL_W];
            end
            for (int p = 0; p < `RTE_NUM_PINS; p++) begin
                outSel_r[p] <= `RTE_OUT_SEL_RST;
            end
            periphIn  <= '0;
            pinOut    <= '0;
            pinOe     <= '0;
            lockedOut <= 1'b0;
        end else begin
            for (int i = 0; i < `RTE_NUM_INPUTS; i++) begin
                inSel_r[i] <= inSel_nxt[i];
            end
            for (int p = 0; p < `RTE_NUM_PINS; p++) begin
                outSel_r[p] <= outSel_nxt[p];
            end
            periphIn  <= periphIn_nxt;
            pinOut    <= drvVal;
            pinOe     <= drvOe;
            lockedOut <= locked_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- dv/rte_assertions.sv ----
// Port-level checker for the pin routing block
`include "rte_consts.svh"
`default_nettype none

module rte_assertions #(
    parameter bit PKG20 = 1'b1                            // Package default set
) (
    input wire logic                        mclk,         // System clock
    input wire logic                        rst_n,        // Power-on reset
    input wire logic                        selWrEn,      // Select write strobe
    input wire logic                        selWrOut,     // Output select flag
    input wire logic [`RTE_IDX_W-1:0]       selWrIdx,     // Select index
    input wire logic [7:0]                  selWrData,    // Select data
    input wire logic                        lockWrEn,     // Lock write strobe
    input wire logic [7:0]                  lockWrData,   // Lock write data
    input wire logic                        otherAccess,  // Other access
    input wire logic                        oneWayCfg,    // One-way option
    input wire logic [`RTE_NUM_PINS-1:0]    pinIn,        // Pin levels
    input wire logic [`RTE_NUM_PINS-1:0]    portLatch,    // Port latches
    input wire logic [`RTE_NUM_PINS-1:0]    pinDirCtrl,   // Direction bits
    input wire logic [`RTE_NUM_INPUTS-1:0]  periphIn,     // Routed inputs
    input wire logic [`RTE_NUM_PINS-1:0]    pinOut,       // Pin levels out
    input wire logic [`RTE_NUM_PINS-1:0]    pinOe,        // Pin enables
    input wire logic                        lockedOut     // Lock bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]               keySt_r, keySt_nxt;
    logic [2:0]               upCnt_r;
    logic                     owSeen_r, outWr_r, keyOk, lockBit;
    logic [4:0]               rxSel_r, selD_r;
    logic [`RTE_NUM_PINS-1:0] pinD1_r, pinD2_r, pinD3_r;

    assign keyOk = keySt_r == 2'd2 && lockWrEn && !selWrEn && !otherAccess;
    assign lockBit = lockWrData[`RTE_LOCK_BIT];
    always_comb begin
        keySt_nxt = keySt_r;
        if (selWrEn || otherAccess)
            keySt_nxt = 2'd0;
        else if (lockWrEn)
            keySt_nxt = (keySt_r == 2'd0 && lockWrData == `RTE_KEY_FIRST) ? 2'd1 :
                        (keySt_r == 2'd1 && lockWrData == `RTE_KEY_SECOND) ? 2'd2 : 2'd0;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            keySt_r <= 2'd0;
            upCnt_r <= 3'd0;
            owSeen_r <= 1'b0;
            outWr_r <= 1'b0;
            rxSel_r <= PKG20 ? `RTE_DEF20_RX1 : `RTE_DEF14_RX1;
            selD_r <= PKG20 ? `RTE_DEF20_RX1 : `RTE_DEF14_RX1;
            pinD1_r <= '0;
            pinD2_r <= '0;
            pinD3_r <= '0;
        end else begin
            keySt_r <= keySt_nxt;
            upCnt_r <= (upCnt_r == 3'd4) ? upCnt_r : upCnt_r + 3'd1;
            owSeen_r <= owSeen_r | ($rose(lockedOut) & $past(oneWayCfg));
            outWr_r <= outWr_r | (selWrEn & selWrOut);
            if (selWrEn && !selWrOut && selWrIdx == 5'(`RTE_IN_RX1) && !lockedOut)
                rxSel_r <= selWrData[4:0];
            selD_r <= rxSel_r;
            pinD1_r <= pinIn;
            pinD2_r <= pinD1_r;
            pinD3_r <= pinD2_r;
        end
    end

    a_lock_keyed: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(lockedOut) |-> $past(keyOk) && lockedOut == $past(lockBit))
        else $error("lock bit changed without the key sequence");
    a_lock_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        (!lockWrEn) [*2] |-> $stable(lockedOut))
        else $error("lock bit changed with no lock write");
    a_other_aborts: assert property (@(posedge mclk) disable iff (!rst_n)
        keySt_r == 2'd2 && otherAccess |=> $stable(lockedOut))
        else $error("interrupted key sequence still changed the lock");
    a_oneway_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        owSeen_r |-> lockedOut)
        else $error("one-way lock was cleared before reset");
    a_latch_default: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n) && !outWr_r |-> pinOut == $past(portLatch))
        else $error("pin not driven from port latch after reset");
    a_dir_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n) && !outWr_r |-> pinOe == ~$past(pinDirCtrl))
        else $error("pin enable not following direction bit");
    a_input_route: assert property (@(posedge mclk) disable iff (!rst_n)
        upCnt_r == 3'd4 |-> periphIn[`RTE_IN_RX1] == (selD_r < 5'd24 ? pinD3_r[selD_r] : 1'b0))
        else $error("receive input not routed from selected pin");
    a_reset_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> !lockedOut && pinOut == '0 && pinOe == '0 && periphIn == '0)
        else $error("outputs not cleared by power-on reset");
endmodule

`default_nettype wire

// ---- dv/rte_periph_model.sv ----
// Peripheral and pin level model facing the routing block
`default_nettype none

module rte_periph_model (
    input  wire logic        mclk,    // System clock
    input  wire logic        hold,    // Freeze all levels
    output var  logic [23:0] pinLvl,  // Pin levels
    output var  logic [31:0] srcLvl,  // Peripheral outputs, bit = code - 1
    output var  logic [8:0]  ovrCtl   // Driver override controls
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 22;

    initial begin
        pinLvl = '0;
        srcLvl = '0;
        ovrCtl = '0;
    end
    always @(posedge mclk) begin
        if (!hold) begin
            pinLvl <= 24'($random(seed));
            srcLvl <= 32'($random(seed));
            ovrCtl <= 9'($random(seed));
        end
    end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench for the pin routing block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam bit PKG20 = 1'b1;
    logic        mclk, rst_n, selWrEn, selWrOut, lockWrEn, otherAccess, oneWayCfg, hold;
    logic        lockedOut;
    logic [4:0]  selWrIdx;
    logic [7:0]  selWrData, lockWrData, periphIn;
    logic [23:0] pinLvl, portLatch, pinDirCtrl, pinOut, pinOe;
    logic [31:0] srcLvl;
    logic [8:0]  ovrCtl;
    integer      seed = 22;
    integer      n_errors = 0;
    integer      cmp_count = 0;
    logic [4:0]  inDef [8] = '{5'b10110, 5'b01111, 5'b01101, 5'b00001,
                               5'b01101, 5'b01111, 5'b10000, 5'b00100};

    rte_periph_model peer_u (.mclk, .hold, .pinLvl, .srcLvl, .ovrCtl);
    rte_pin_routing #(.PKG20(PKG20)) dut_u (
        .mclk, .rst_n, .selWrEn, .selWrOut, .selWrIdx, .selWrData, .lockWrEn, .lockWrData,
        .otherAccess, .oneWayCfg, .pinIn(pinLvl), .portLatch, .pinDirCtrl,
        .logicCellOut(srcLvl[3:0]), .wave1Out(srcLvl[7:4]), .capCompOut(srcLvl[11:8]),
        .pwmOut(srcLvl[13:12]), .serTxCk(srcLvl[14]), .serDt(srcLvl[15]),
        .cmpOut(srcLvl[17:16]), .sspClk({srcLvl[20], srcLvl[18]}),
        .sspDat({srcLvl[21], srcLvl[19]}), .timer_zero_output(srcLvl[22]), .numOscOut(srcLvl[23]),
        .refClkOut(srcLvl[24]), .modOut(srcLvl[25]), .wave2Out(srcLvl[29:26]),
        .guardOut(srcLvl[31:30]), .serSyncMode(ovrCtl[0]), .serCkOe(ovrCtl[1]),
        .serDtOe(ovrCtl[2]), .sspI2cMode(ovrCtl[4:3]), .sspClkOe(ovrCtl[6:5]),
        .sspDatOe(ovrCtl[8:7]), .periphIn, .pinOut, .pinOe, .lockedOut);

    function automatic logic expOut(input logic [5:0] c, input int p);
        if (c == 6'h00)
            return portLatch[p];
        return (c <= 6'h20) ? srcLvl[c - 6'd1] : 1'b0;
    endfunction
    function automatic logic expOe(input logic [5:0] c, input int p);
        case (c)
            6'h0f: return ovrCtl[0] ? ovrCtl[1] : ~pinDirCtrl[p];
            6'h10: return ovrCtl[0] ? ovrCtl[2] : ~pinDirCtrl[p];
            6'h13: return ovrCtl[3] ? ovrCtl[5] : ~pinDirCtrl[p];
            6'h14: return ovrCtl[3] ? ovrCtl[7] : ~pinDirCtrl[p];
            6'h15: return ovrCtl[4] ? ovrCtl[6] : ~pinDirCtrl[p];
            6'h16: return ovrCtl[4] ? ovrCtl[8] : ~pinDirCtrl[p];
            default: return ~pinDirCtrl[p];
        endcase
    endfunction

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic selWr(input logic o, input logic [4:0] i, input logic [7:0] d);
        @(posedge mclk);
        selWrEn <= 1'b1;
        selWrOut <= o;
        selWrIdx <= i;
        selWrData <= d;
        @(posedge mclk);
        selWrEn <= 1'b0;
    endtask
    task automatic lockWr(input logic [7:0] d);
        @(posedge mclk);
        lockWrEn <= 1'b1;
        lockWrData <= d;
        @(posedge mclk);
        lockWrEn <= 1'b0;
    endtask
    task automatic upd(input logic [7:0] d, input logic exp);
        lockWr(d);
        #1;
        chk("lockedOut", 24'(exp), 24'(lockedOut));
    endtask
    task automatic keyed(input logic [7:0] d, input logic exp);
        lockWr(8'h55);
        lockWr(8'haa);
        upd(d, exp);
    endtask
    // Write one select with sources frozen, then compare the routed level
    task automatic route(input logic o, input int i, input logic [5:0] w, input logic [5:0] e);
        hold <= 1'b0;
        repeat (2) @(posedge mclk);
        hold <= 1'b1;
        selWr(o, 5'(i), {2'b00, w});
        repeat (3) @(posedge mclk);
        #1;
        if (o) begin
            chk("pinOut", 24'(expOut(e, i)), 24'(pinOut[i]));
            chk("pinOe", 24'(expOe(e, i)), 24'(pinOe[i]));
        end else
            chk("periphIn", 24'(e < 6'd24 ? pinLvl[e] : 1'b0), 24'(periphIn[i]));
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (!hold) begin
            portLatch <= 24'($random(seed));
            pinDirCtrl <= 24'($random(seed));
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results();
    end
    initial begin
        int c;
        {rst_n, selWrEn, selWrOut, lockWrEn, otherAccess, oneWayCfg, hold} = '0;
        {selWrIdx, selWrData, lockWrData, portLatch, pinDirCtrl} = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        hold <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        for (int k = 0; k < 8; k++)
            chk("periphIn", 24'(pinLvl[inDef[k]]), 24'(periphIn[k]));
        chk("pinOut", portLatch, pinOut);
        chk("pinOe", ~pinDirCtrl, pinOe);
        $display("test defaults done");
        for (int n = 0; n <= 34; n++)
            route(1'b1, {$random(seed)} % 24, 6'(n), 6'(n));
        for (int n = 0; n < 16; n++) begin
            c = {$random(seed)} % 32;
            route(1'b0, n % 8, 6'(c), 6'(c));
        end
        route(1'b0, 4, 6'd9, 6'd9);
        route(1'b1, 9, 6'h10, 6'h10);
        $display("test routing done");
        keyed(8'h01, 1'b1);
        route(1'b1, 9, 6'h01, 6'h10);
        route(1'b0, 4, 6'd3, 6'd9);
        lockWr(8'h55);
        lockWr(8'haa);
        @(posedge mclk);
        otherAccess <= 1'b1;
        @(posedge mclk);
        otherAccess <= 1'b0;
        upd(8'h00, 1'b1);
        lockWr(8'h55);
        selWr(1'b0, 5'd4, 8'h03);
        lockWr(8'haa);
        upd(8'h00, 1'b1);
        keyed(8'h00, 1'b0);
        $display("test lock done");
        oneWayCfg <= 1'b1;
        keyed(8'h01, 1'b1);
        keyed(8'h00, 1'b1);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk("lockedOut", 24'd0, 24'(lockedOut));
        chk("periphIn", 24'(pinLvl[inDef[4]]), 24'(periphIn[4]));
        chk("pinOut", portLatch, pinOut);
        keyed(8'h00, 1'b0);
        keyed(8'h01, 1'b1);
        keyed(8'h00, 1'b1);
        $display("test one-way done");
        results();
    end
endmodule

bind rte_pin_routing rte_assertions #(.PKG20(PKG20)) chk_u (
    .mclk, .rst_n, .selWrEn, .selWrOut, .selWrIdx, .selWrData, .lockWrEn, .lockWrData,
    .otherAccess, .oneWayCfg, .pinIn, .portLatch, .pinDirCtrl, .periphIn, .pinOut, .pinOe,
    .lockedOut);

`default_nettype wire
